/* logic/sfrc_core.sv */
// Notes on behaviour
// - Extended uses one lane in, separate lane out; dual two, quad four lanes.
// - Chip select high ends any read and output drive stops at once.
// - Status register readable repeatedly and at any time, even while busy.
// - Flag status readable repeatedly and at any time, even while busy.
// - Nonvolatile config read gives 16 bits then zeros; reserved reads one.
// - Volatile and enhanced volatile config reads repeat the same byte.
// - Status write only accepted when write enable latch already set.
// - Status and volatile writes end after eighth bit; starts timed write.
// - Status write changes only bits 7:2, never bits 1:0.
// - Timed write sets busy, clears enable latch, then clears busy.
// - Nonvolatile write takes two bytes low first, ends after 16 bits.
// - Wrong chip select boundary: no write, no error flag, latch kept.
// - Volatile config writes keep reserved bits unchanged.
// - Lock read takes three address bytes on rise, shifts out on fall.
// - Lock read during a busy cycle is rejected; cycle unaffected.
// - Lock byte bits 7:2 read zero; bit 0 blocks program and erase.
// - Lock-down bit set forbids further lock writes to that sector until reset.
// - Lock write needs latch, three address bytes and one data byte.
// - Lock write applies at once, sets no error, clears the latch.
// - Lock write is accepted while an erase is suspended.
// - Clear flag command resets erase, program and protection errors.
// - Error flags stay set until cleared by the clear flag command.
// - Status read 05h, flag read 70h, clear flag 50h in all protocols.
// - Register commands other than lock read and write have no address bytes and no dummy cycles.
`timescale 1ns/100ps
`default_nettype none
module sfrc_core
  import sfrc_pkg::*;
(
  input  wire logic       I_SYS_CLK,     // System clock, 100 MHz
  input  wire logic       I_SYS_RST,     // Sync reset, active high
  input  wire logic       I_SCLK,        // Serial clock pin
  input  wire logic       I_CS_N,        // Chip select pin, low active
  input  wire logic [3:0] I_DQ,          // Data lanes in
  input  wire logic [1:0] I_PROTO,       // Lane protocol select
  input  wire logic       I_PE_BUSY,     // Array program/erase running
  input  wire logic       I_ERASE_SUSP,  // Erase suspended
  input  wire logic [2:0] I_ERR_SET,     // Error events: erase/prog/prot
  input  wire logic [5:0] I_LOCK_SEC,    // Sector queried by array logic
  output logic      [3:0] O_DQ,          // Data lanes out
  output logic      [3:0] O_DQ_OE_N,     // Lane enables, low drives
  output logic            O_WIP,         // Write in progress
  output logic            O_LOCK_WL,     // Write lock of queried sector
  output logic     [15:0] O_NVCFG,       // Nonvolatile config contents
  output logic      [7:0] O_VCFG,        // Volatile config contents
  output logic      [7:0] O_EVCFG        // Enhanced volatile config
);

  typedef struct packed {
    logic [2:0]               sclk_s;
    logic [2:0]               cs_s;
    logic [2:0][3:0]          dq_s;
    logic                     sclk_f;
    logic                     cs_n_f;
    sfrc_state_e              st;
    logic [7:0]               cmd;
    logic [23:0]              sh;
    logic [5:0]               nbits;
    logic [23:0]              addr;
    logic [7:0]               osh;
    logic [2:0]               obit;
    logic [1:0]               oidx;
    logic [5:0]               sr_hi;
    logic                     wel;
    logic                     wbusy;
    logic [15:0]              wtmr;
    logic [2:0]               err;
    logic [15:0]              nvcfg;
    logic [7:0]               vcfg;
    logic [7:0]               evcfg;
    logic [N_SECT-1:0][1:0]   lock;
    logic [3:0]               dq_o;
    logic [3:0]               dq_oe_n;
    logic                     wip_o;
    logic                     wl_o;
  } sfrc_state_s;

  sfrc_state_s q;
  sfrc_state_s d;

  function automatic logic [5:0] lane_w(input logic [1:0] p);
    case (p)
      PROTO_DUAL: lane_w = 6'h02;
      PROTO_QUAD: lane_w = 6'h04;
      default:    lane_w = 6'h01;
    endcase
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] s,
                                           input logic [3:0]  dq,
                                           input logic [1:0]  p);
    case (p)
      PROTO_DUAL: shift_in = {s[21:0], dq[1:0]};
      PROTO_QUAD: shift_in = {s[19:0], dq};
      default:    shift_in = {s[22:0], dq[0]};
    endcase
  endfunction

  logic              sclk_ok;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              cs_ok;
  logic              cs_up;
  logic              cs_dn;
  logic              wip;
  logic [5:0]        w;
  logic [5:0]        nb_next;
  logic [23:0]       sh_next;
  logic [7:0]        fsr_b;
  logic [7:0]        rd_b;
  logic [7:0]        cur;
  logic [5:0]        sec;
  logic [5:0]        need;
  logic              lock_ok;

  always_comb begin
    d = q;
    w = lane_w(I_PROTO);
    sec = q.addr[SECT_MSB:SECT_LSB];
    // Three-stage sync; a level counts once stages two and three agree
    d.sclk_s = {q.sclk_s[1:0], I_SCLK};
    d.cs_s   = {q.cs_s[1:0], I_CS_N};
    d.dq_s   = {q.dq_s[1:0], I_DQ};
    sclk_ok  = q.sclk_s[1] == q.sclk_s[2];
    cs_ok    = q.cs_s[1] == q.cs_s[2];
    if (sclk_ok) begin
      d.sclk_f = q.sclk_s[2];
    end
    if (cs_ok) begin
      d.cs_n_f = q.cs_s[2];
    end
    sclk_rise = sclk_ok & q.sclk_s[2] & ~q.sclk_f;
    sclk_fall = sclk_ok & ~q.sclk_s[2] & q.sclk_f;
    cs_up     = cs_ok & q.cs_s[2] & ~q.cs_n_f;
    cs_dn     = cs_ok & ~q.cs_s[2] & q.cs_n_f;

    wip = q.wbusy | I_PE_BUSY;
    sh_next = shift_in(q.sh, q.dq_s[2], I_PROTO);
    nb_next = (q.nbits > 6'h3B) ? q.nbits : q.nbits + w;
    need = (q.cmd == CMD_WR_NVCFG) ? NV_BITS : BYTE_BITS;
    // Suspended erase leaves the lock register writable
    lock_ok = ~q.wbusy & (~I_PE_BUSY | I_ERASE_SUSP);

    // Self-timed write countdown
    if (q.wbusy) begin
      if (q.wtmr <= 16'h0001) begin
        d.wbusy = 1'b0;
      end else begin
        d.wtmr = q.wtmr - 16'h0001;
      end
    end

    // Errors are sticky; a new event beats a same-cycle clear
    d.err = q.err | I_ERR_SET;

    fsr_b = 8'h00;
    fsr_b[FSR_PEC_RDY]   = ~wip;
    fsr_b[FSR_ERASE_ERR] = q.err[ERR_ERASE];
    fsr_b[FSR_PROG_ERR]  = q.err[ERR_PROG];
    fsr_b[FSR_PROT_ERR]  = q.err[ERR_PROT];

    // Byte for the output phase, fetched live at each byte start
    case (q.cmd)
      CMD_RD_STATUS: rd_b = {q.sr_hi, q.wel, wip};
      CMD_RD_FLAG:   rd_b = fsr_b;
      CMD_RD_NVCFG: begin
        case (q.oidx)
          2'h0:    rd_b = q.nvcfg[7:0] | NVCFG_RSVD[7:0];
          2'h1:    rd_b = q.nvcfg[15:8] | NVCFG_RSVD[15:8];
          default: rd_b = 8'h00;
        endcase
      end
      CMD_RD_VCFG:   rd_b = q.vcfg;
      CMD_RD_EVCFG:  rd_b = q.evcfg;
      CMD_RD_LOCK:   rd_b = {6'h00, q.lock[sec]};
      default:       rd_b = 8'h00;
    endcase
    cur = (q.obit == 3'h0) ? rd_b : q.osh;

    if (cs_dn) begin
      d.st      = ST_CMD;
      d.nbits   = 6'h00;
      d.sh      = 24'h00_0000;
      d.dq_oe_n = 4'hF;
    end else if (cs_up) begin
      // Deselect releases the lanes at once
      d.st      = ST_IDLE;
      d.dq_oe_n = 4'hF;
      // Commit only on an exact bit boundary with the latch set
      if (q.st == ST_DIN && q.nbits == need && q.wel) begin
        case (q.cmd)
          CMD_WR_STATUS: begin
            if (!wip) begin
              d.sr_hi = q.sh[7:2];
              d.wbusy = 1'b1;
              d.wtmr  = STATUS_WRITE_CYC;
              d.wel   = 1'b0;
            end
          end
          CMD_WR_NVCFG: begin
            if (!wip) begin
              d.nvcfg = {q.sh[7:0], q.sh[15:8]};
              d.wbusy = 1'b1;
              d.wtmr  = NV_CONFIG_WRITE_CYC;
              d.wel   = 1'b0;
            end
          end
          CMD_WR_VCFG: begin
            if (!wip) begin
              d.vcfg  = (q.vcfg & VCFG_RSVD)
                      | (q.sh[7:0] & ~VCFG_RSVD);
              d.wbusy = 1'b1;
              d.wtmr  = STATUS_WRITE_CYC;
              d.wel   = 1'b0;
            end
          end
          CMD_WR_EVCFG: begin
            if (!wip) begin
              d.evcfg = (q.evcfg & EVCFG_RSVD)
                      | (q.sh[7:0] & ~EVCFG_RSVD);
              d.wbusy = 1'b1;
              d.wtmr  = STATUS_WRITE_CYC;
              d.wel   = 1'b0;
            end
          end
          CMD_WR_LOCK: begin
            if (lock_ok) begin
              if (!q.lock[sec][LK_LOCK_DOWN]) begin
                d.lock[sec] = q.sh[1:0];
              end
              // Latch drops in one cycle, well inside deselect time
              d.wel = 1'b0;
            end
          end
          default: d.wel = q.wel;
        endcase
      end
    end else if (sclk_rise) begin
      case (q.st)
        ST_CMD: begin
          d.sh    = sh_next;
          d.nbits = nb_next;
          if (nb_next == CMD_BITS) begin
            d.cmd   = sh_next[7:0];
            d.nbits = 6'h00;
            d.obit  = 3'h0;
            d.oidx  = 2'h0;
            case (sh_next[7:0])
              CMD_RD_STATUS, CMD_RD_FLAG, CMD_RD_NVCFG,
              CMD_RD_VCFG, CMD_RD_EVCFG: begin
                d.st = ST_DOUT;
              end
              CMD_RD_LOCK, CMD_WR_LOCK: d.st = ST_ADDR;
              CMD_WR_STATUS, CMD_WR_NVCFG,
              CMD_WR_VCFG, CMD_WR_EVCFG: d.st = ST_DIN;
              CMD_WR_EN: begin
                d.wel = 1'b1;
                d.st  = ST_IGN;
              end
              CMD_WR_DIS: begin
                d.wel = 1'b0;
                d.st  = ST_IGN;
              end
              CMD_CLR_FLAG: begin
                d.err = I_ERR_SET;
                d.st  = ST_IGN;
              end
              default: d.st = ST_IGN;
            endcase
          end
        end
        ST_ADDR: begin
          d.sh    = sh_next;
          d.nbits = nb_next;
          if (nb_next == ADDR_BITS) begin
            d.addr  = sh_next;
            d.nbits = 6'h00;
            if (q.cmd == CMD_WR_LOCK) begin
              d.st = ST_DIN;
            end else if (wip) begin
              d.st = ST_IGN;
            end else begin
              d.st = ST_DOUT;
            end
          end
        end
        ST_DIN: begin
          d.sh    = sh_next;
          d.nbits = nb_next;
        end
        default: d.st = q.st;
      endcase
    end else if (sclk_fall && q.st == ST_DOUT) begin
      // Shift on falling edges so the host samples on the rise
      d.dq_o = 4'h0;
      case (I_PROTO)
        PROTO_DUAL: begin
          d.dq_o[1:0] = cur[7:6];
          d.dq_oe_n   = 4'hC;
        end
        PROTO_QUAD: begin
          d.dq_o      = cur[7:4];
          d.dq_oe_n   = 4'h0;
        end
        default: begin
          d.dq_o[1]   = cur[7];
          d.dq_oe_n   = 4'hD;
        end
      endcase
      d.osh  = 8'(cur << w);
      d.obit = q.obit + w[2:0];
      if (6'(q.obit) + w == BYTE_BITS && q.oidx != 2'h3) begin
        d.oidx = q.oidx + 2'h1;
      end
    end

    d.wip_o = d.wbusy | I_PE_BUSY;
    d.wl_o  = q.lock[I_LOCK_SEC][LK_WRITE_LOCK];
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      q         <= '0;
      q.cs_s    <= 3'h7;
      q.cs_n_f  <= 1'b1;
      q.dq_oe_n <= 4'hF;
      q.nvcfg   <= NVCFG_RST;
      q.vcfg    <= VCFG_RST;
      q.evcfg   <= EVCFG_RST;
    end else begin
      q <= d;
    end
  end

  assign O_DQ      = q.dq_o;
  assign O_DQ_OE_N = q.dq_oe_n;
  assign O_WIP     = q.wip_o;
  assign O_LOCK_WL = q.wl_o;
  assign O_NVCFG   = q.nvcfg;
  assign O_VCFG    = q.vcfg;
  assign O_EVCFG   = q.evcfg;

endmodule
`default_nettype wire

/* logic/sfrc_pkg.sv */
`default_nettype none
package sfrc_pkg;

  // Command codes, identical in all three lane protocols
  localparam logic [7:0] CMD_RD_STATUS = 8'h05;
  localparam logic [7:0] CMD_WR_STATUS = 8'h01;
  localparam logic [7:0] CMD_RD_FLAG   = 8'h70;
  localparam logic [7:0] CMD_CLR_FLAG  = 8'h50;
  localparam logic [7:0] CMD_RD_NVCFG  = 8'hB5;
  localparam logic [7:0] CMD_WR_NVCFG  = 8'hB1;
  localparam logic [7:0] CMD_RD_VCFG   = 8'h85;
  localparam logic [7:0] CMD_WR_VCFG   = 8'h81;
  localparam logic [7:0] CMD_RD_EVCFG  = 8'h65;
  localparam logic [7:0] CMD_WR_EVCFG  = 8'h61;
  localparam logic [7:0] CMD_RD_LOCK   = 8'hE8;
  localparam logic [7:0] CMD_WR_LOCK   = 8'hE5;
  localparam logic [7:0] CMD_WR_EN     = 8'h06;
  localparam logic [7:0] CMD_WR_DIS    = 8'h04;

  // Lane protocol select
  localparam logic [1:0] PROTO_EXT  = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;

  // Status and flag status bit positions
  localparam int SR_WIP        = 0;
  localparam int SR_WEL        = 1;
  localparam int FSR_PEC_RDY   = 7;
  localparam int FSR_ERASE_ERR = 5;
  localparam int FSR_PROG_ERR  = 4;
  localparam int FSR_PROT_ERR  = 1;
  // Index of each error event on the error input
  localparam int ERR_ERASE     = 0;
  localparam int ERR_PROG      = 1;
  localparam int ERR_PROT      = 2;

  // Lock byte fields and sector decode
  localparam int LK_WRITE_LOCK = 0;
  localparam int LK_LOCK_DOWN  = 1;
  localparam int SECT_LSB      = 16;
  localparam int SECT_MSB      = 21;
  localparam int N_SECT        = 64;

  // Frame bit counts
  localparam logic [5:0] CMD_BITS  = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] NV_BITS   = 6'h10;

  // Reset values and reserved masks
  localparam logic [15:0] NVCFG_RST  = 16'hFFFF;
  localparam logic [7:0]  VCFG_RST   = 8'hFF;
  localparam logic [7:0]  EVCFG_RST  = 8'hFF;
  localparam logic [15:0] NVCFG_RSVD = 16'h0010;
  localparam logic [7:0]  VCFG_RSVD  = 8'h04;
  localparam logic [7:0]  EVCFG_RSVD = 8'h10;

  // Timing
  localparam int SYS_CLK_PERIOD_NS          = 10;
  localparam int STATUS_WRITE_TIME_NS       = 1000;
  localparam int NV_CONFIG_WRITE_TIME_NS    = 2000;
  localparam int LOCK_WRITE_DESELECT_TIME_NS = 20;
  localparam logic [15:0] STATUS_WRITE_CYC = 16'(
    (STATUS_WRITE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
  localparam logic [15:0] NV_CONFIG_WRITE_CYC = 16'(
    (NV_CONFIG_WRITE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DIN, ST_DOUT, ST_IGN
  } sfrc_state_e;

endpackage
`default_nettype wire

/* dv/sfrc_core_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module sfrc_core_properties
  import sfrc_pkg::*;
(
  input wire logic        I_SYS_CLK,  // Clock
  input wire logic        I_SYS_RST,  // Reset
  input wire logic        I_SCLK,     // Serial clock pin
  input wire logic        I_CS_N,     // Chip select pin
  input wire logic [1:0]  I_PROTO,    // Lane protocol
  input wire logic        I_PE_BUSY,  // Array busy
  input wire logic [5:0]  I_LOCK_SEC, // Queried sector
  input wire logic [3:0]  O_DQ,       // Lanes out
  input wire logic [3:0]  O_DQ_OE_N,  // Lane enables
  input wire logic        O_WIP,      // Busy
  input wire logic        O_LOCK_WL,  // Lock bit
  input wire logic [15:0] O_NVCFG,    // NV config
  input wire logic [7:0]  O_VCFG,     // V config
  input wire logic [7:0]  O_EVCFG     // EV config
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic       pe_q;
  logic [8:0] wcnt_q;
  // Counts busy time owed to timed writes only
  always_ff @(posedge I_SYS_CLK) begin
    pe_q   <= I_PE_BUSY;
    wcnt_q <= (O_WIP && !pe_q && !I_SYS_RST) ? wcnt_q + 9'h001 : 9'h000;
  end
  reset_values_a: assert property (
    $fell(I_SYS_RST) |-> O_DQ_OE_N == 4'hF && !O_WIP && !O_LOCK_WL &&
    O_NVCFG == 16'hFFFF && O_VCFG == 8'hFF && O_EVCFG == 8'hFF)
    else $error("reset values wrong");
  lane_enable_a: assert property (
    O_DQ_OE_N != 4'hF |-> O_DQ_OE_N == (I_PROTO == PROTO_QUAD ? 4'h0 :
    I_PROTO == PROTO_DUAL ? 4'hC : 4'hD))
    else $error("lane enables wrong");
  cs_release_a: assert property (
    I_CS_N [*7] |-> O_DQ_OE_N == 4'hF)
    else $error("lanes driven while deselected");
  wip_follow_a: assert property (
    I_PE_BUSY |=> O_WIP)
    else $error("busy not shown");
  wip_bound_a: assert property (
    wcnt_q <= 9'h0D2)
    else $error("timed write too long");
  wip_min_a: assert property (
    $fell(O_WIP) && wcnt_q != 9'h000 |-> wcnt_q >= 9'h05A)
    else $error("timed write too short");
  rsvd_keep_a: assert property (
    O_VCFG[2] == $past(O_VCFG[2]) && O_EVCFG[4] == $past(O_EVCFG[4]))
    else $error("reserved config bit changed");
  dout_fall_a: assert property (
    $changed(O_DQ) && O_DQ_OE_N != 4'hF |-> !$past(I_SCLK, 3))
    else $error("data moved off falling clock");
  lock_rise_a: assert property (
    $changed(O_LOCK_WL) && $past(I_LOCK_SEC) == $past(I_LOCK_SEC, 2)
    |-> $past(I_CS_N, 3))
    else $error("lock bit changed inside frame");
endmodule
bind sfrc_core sfrc_core_properties u_props (
  .I_SYS_CLK, .I_SYS_RST, .I_SCLK, .I_CS_N, .I_PROTO, .I_PE_BUSY,
  .I_LOCK_SEC, .O_DQ, .O_DQ_OE_N, .O_WIP, .O_LOCK_WL, .O_NVCFG,
  .O_VCFG, .O_EVCFG);
`default_nettype wire

/* dv/sfrc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sfrc_host
  import sfrc_pkg::*;
(
  output var logic       o_sclk, // Serial clock, low between frames
  output var logic       o_cs_n, // Chip select
  output var logic [3:0] o_dq,   // Lanes toward device
  input  wire logic [3:0] i_dq   // Resolved lanes
);
  localparam realtime HP = 62.5;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq   = 4'h5;
  end
  task automatic send(input logic [23:0] v, input int n, input int w);
    for (int i = 23; i > 23 - n; i -= w) begin
      for (int k = 0; k < w; k++)
        o_dq[w-1-k] = v[i-k];
      #HP o_sclk = 1'b1;
      #HP o_sclk = 1'b0;
    end
  endtask
  task automatic xfer(input logic [1:0] pr, input logic [7:0] c,
                      input logic [23:0] a, input int na,
                      input logic [15:0] wd, input int nw, input int nr,
                      output logic [31:0] rd);
    int w;
    w = (pr == PROTO_DUAL) ? 2 : (pr == PROTO_QUAD) ? 4 : 1;
    rd = '0;
    o_cs_n = 1'b0;
    #HP;
    send({c, 16'h0000}, 8, w);
    send(a, na, w);
    send({wd, 8'h00}, nw, w);
    for (int i = 0; i < nr; i += w) begin
      // Released lanes toggle so stale values never read as data
      o_dq = ~o_dq;
      #HP o_sclk = 1'b1;
      for (int k = w - 1; k >= 0; k--)
        rd = {rd[30:0], (w == 1) ? i_dq[1] : i_dq[k]};
      #HP o_sclk = 1'b0;
    end
    #HP o_cs_n = 1'b1;
    o_dq = ~o_dq;
    #200;
  endtask
endmodule
`default_nettype wire

/* dv/sfrc_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sfrc_tb_top
  import sfrc_pkg::*;
;
  logic        clk, rst, busy, susp, sclk, cs_n, drove, wip, lwl;
  logic [2:0]  err, ev;
  logic [5:0]  sec;
  logic [1:0]  pr;
  logic [3:0]  hdq, ddq, oe_n, dqw;
  logic [31:0] r;
  logic [15:0] nv, nvo;
  logic [7:0]  d, sr, vc, evc, vo, evo;
  int          seed, n_errors, checks, cyc, n;
  assign dqw = (oe_n & hdq) | (~oe_n & ddq);
  sfrc_core u_sfrc_core (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_DQ(dqw), .I_PROTO(pr), .I_PE_BUSY(busy), .I_ERASE_SUSP(susp),
    .I_ERR_SET(err), .I_LOCK_SEC(sec), .O_DQ(ddq), .O_DQ_OE_N(oe_n),
    .O_WIP(wip), .O_LOCK_WL(lwl), .O_NVCFG(nvo), .O_VCFG(vo),
    .O_EVCFG(evo));
  sfrc_host u_sfrc_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq(hdq),
                         .i_dq(dqw));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] st(input logic wel, input logic wp);
    return {sr[7:2], wel, wp};
  endfunction
  function automatic logic [7:0] fl(input logic wp, input logic [2:0] e);
    return {~wp, 1'b0, e[ERR_ERASE], e[ERR_PROG], 2'b00, e[ERR_PROT], 1'b0};
  endfunction
  function automatic logic [7:0] mg(input logic [7:0] o, w, m);
    return (w & ~m) | (o & m);
  endfunction
  task automatic final_report;
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [23:0] e, g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [23:0] a, input int na,
                    input logic [15:0] w, input int nw, input int nr);
    u_sfrc_host.xfer(pr, c, a, na, w, nw, nr, r);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] c, input int nr);
    op(c, '0, 0, '0, 0, nr);
  endtask
  // Polls the busy pin instead of the bus, so frames never overlap
  task automatic idle(input int lo, input int hi);
    n = 0;
    while (wip === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("write time", 24'h1, 24'(n >= lo && n <= hi));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (oe_n !== 4'hF)
      drove = 1'b1;
    if (cyc == 50000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    seed = 93; n_errors = 0; checks = 0; cyc = 0; drove = 1'b0;
    rst = 1'b1; busy = 1'b0; susp = 1'b0; err = '0; sec = '0;
    pr = PROTO_EXT; sr = '0; vc = VCFG_RST; evc = EVCFG_RST;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk("nvcfg", 24'(NVCFG_RST), 24'(nvo));
    rd(CMD_WR_EN, 0);
    op(CMD_WR_STATUS, '0, 0, '0, 8, 0);
    idle(75, 95);
    for (int p = 0; p < 3; p++) begin
      pr = 2'(p);
      d = 8'($random(seed));
      op(CMD_WR_STATUS, '0, 0, {d, 8'h00}, 8, 0);
      rd(CMD_RD_STATUS, 16);
      chk("status", 24'({2{st(1'b0, 1'b0)}}), r[23:0]);
      rd(CMD_WR_EN, 0);
      op(CMD_WR_STATUS, '0, 0, {d, d}, 16, 0);
      rd(CMD_RD_STATUS, 8);
      chk("status", 24'(st(1'b1, 1'b0)), r[23:0]);
      op(CMD_WR_STATUS, '0, 0, {d, 8'h00}, 8, 0);
      chk("busy", 24'h1, 24'(wip));
      idle(75, 95);
      sr = d;
      rd(CMD_RD_STATUS, 8);
      chk("status", 24'(st(1'b0, 1'b0)), r[23:0]);
      // Reserved bit written as zero so the forced-one read path is seen
      nv = 16'($random(seed)) & ~NVCFG_RSVD;
      rd(CMD_WR_EN, 0);
      op(CMD_WR_NVCFG, '0, 0, {nv[7:0], nv[15:8]}, 16, 0);
      idle(175, 195);
      chk("nvcfg", 24'(nv), 24'(nvo));
      rd(CMD_RD_NVCFG, 24);
      chk("nv read", {nv[7:0] | NVCFG_RSVD[7:0],
                      nv[15:8] | NVCFG_RSVD[15:8], 8'h00}, r[23:0]);
      for (int j = 0; j < 2; j++) begin
        d = 8'($random(seed));
        rd(CMD_WR_EN, 0);
        op(j ? CMD_WR_EVCFG : CMD_WR_VCFG, '0, 0, {d, 8'h00}, 8, 0);
        idle(75, 95);
        if (j == 0)
          vc = mg(vc, d, VCFG_RSVD);
        else
          evc = mg(evc, d, EVCFG_RSVD);
        chk("vcfg", 24'(j ? evc : vc), 24'(j ? evo : vo));
        rd(j ? CMD_RD_EVCFG : CMD_RD_VCFG, 24);
        chk("vcfg read", j ? {3{evc}} : {3{vc}}, r[23:0]);
      end
      // One forced bit per pass so the clear always has work to do
      ev = 3'($random(seed)) | 3'(1 << p);
      err = ev;
      @(negedge clk);
      err = '0;
      rd(CMD_RD_FLAG, 16);
      chk("flags", 24'({2{fl(1'b0, ev)}}), r[23:0]);
      rd(CMD_CLR_FLAG, 0);
      rd(CMD_RD_FLAG, 8);
      chk("flags", 24'(fl(1'b0, 3'h0)), r[23:0]);
      sec = 6'($random(seed));
      rd(CMD_WR_EN, 0);
      op(CMD_WR_LOCK, {2'b00, sec, 16'h0000}, 24, 16'h0100, 8, 0);
      chk("lock bit", 24'h1, 24'(lwl));
      op(CMD_RD_LOCK, {2'b00, sec, 16'h0000}, 24, '0, 0, 16);
      chk("lock read", 24'h0101, r[23:0]);
      rd(CMD_RD_STATUS, 8);
      chk("status", 24'(st(1'b0, 1'b0)), r[23:0]);
    end
    pr = PROTO_EXT;
    busy = 1'b1;
    repeat (2) @(negedge clk);
    rd(CMD_RD_STATUS, 8);
    chk("status", 24'(st(1'b0, 1'b1)), r[23:0]);
    rd(CMD_RD_FLAG, 8);
    chk("flags", 24'(fl(1'b1, 3'h0)), r[23:0]);
    drove = 1'b0;
    op(CMD_RD_LOCK, '0, 24, '0, 0, 16);
    chk("lock refused", 24'h0, 24'(drove));
    chk("busy kept", 24'h1, 24'(wip));
    susp = 1'b1;
    sec = sec ^ 6'h01;
    rd(CMD_WR_EN, 0);
    op(CMD_WR_LOCK, {2'b00, sec, 16'h0000}, 24, 16'h0300, 8, 0);
    chk("lock suspended", 24'h1, 24'(lwl));
    busy = 1'b0;
    susp = 1'b0;
    rd(CMD_WR_EN, 0);
    op(CMD_WR_LOCK, {2'b00, sec, 16'h0000}, 24, '0, 8, 0);
    op(CMD_RD_LOCK, {2'b00, sec, 16'h0000}, 24, '0, 0, 8);
    chk("lock down", 24'h0003, r[23:0]);
    // Write disable must undo a prior enable, so this write is refused
    rd(CMD_WR_EN, 0);
    rd(CMD_WR_DIS, 0);
    op(CMD_WR_STATUS, '0, 0, ~{sr, sr}, 8, 0);
    rd(CMD_RD_STATUS, 8);
    chk("write disable", 24'(st(1'b0, 1'b0)), r[23:0]);
    rd(CMD_RD_VCFG, 3);
    chk("released", 24'h000F, 24'(oe_n));
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk("lock reset", 24'h0, 24'(lwl));
    final_report;
  end
endmodule
`default_nettype wire
